/* File: src/ecr_regs_map.vh */
// Register map constants for the echo canceller control register bank
`ifndef ECR_REGS_MAP_VH
`define ECR_REGS_MAP_VH

// ****************************************************************
// Offsets
// ****************************************************************
`define ECR_ADDR_MAIN_CTRL    8'h00
`define ECR_ADDR_LINE_CTRL    8'h01
`define ECR_ADDR_LINE_STATUS  8'h02
`define ECR_ADDR_ACOU_CTRL    8'h21
`define ECR_ADDR_ACOU_STATUS  8'h22

// ****************************************************************
// Reset values
// ****************************************************************
`define ECR_RST_MAIN_CTRL     8'h00
`define ECR_RST_LINE_CTRL     8'h00
`define ECR_RST_ACOU_CTRL     8'h00

// ****************************************************************
// Main control fields
// ****************************************************************
`define ECR_MC_SOFT_RESET     0
`define ECR_MC_HOWL_OFF       1
`define ECR_MC_AGC_OFF        2
`define ECR_MC_TONE_OFF       3
`define ECR_MC_BYPASS         4
`define ECR_MC_MUTE_SEND      5
`define ECR_MC_MUTE_RECV      6
`define ECR_MC_LIMIT          7

// ****************************************************************
// Canceller control fields (line and acoustic share layout)
// ****************************************************************
`define ECR_CC_EST_OFF        0
`define ECR_CC_LEARN_OFF      1
`define ECR_CC_COEF_CLEAR     2
`define ECR_CC_OFFSET_OFF     3
`define ECR_CC_NOISE_OFF      4
`define ECR_CC_SUPP_OFF       5
`define ECR_CC_SPEED_OFF      6
`define ECR_CC_TOP            7

// ****************************************************************
// Status fields
// ****************************************************************
`define ECR_ST_TONE_PATH      0
`define ECR_ST_TONE_ANY       1
`define ECR_ST_DOUBLE_TALK    2
`define ECR_ST_SUPP_ACTIVE    3
`define ECR_ST_HOWL           5
`define ECR_ST_RECV_IDLE      6

// ****************************************************************
// Timing
// ****************************************************************
`define ECR_INIT_CYCLES       4'h8
`define ECR_SCALE_SHIFT       2

`endif

/* File: src/ecr_regs.v */
// Control and status register bank of the dual echo canceller
`timescale 1ns/100ps
`default_nettype none
`include "ecr_regs_map.vh"

module ecr_regs #(
  parameter INIT_CYCLES = `ECR_INIT_CYCLES
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        send_linear,
  input  wire        recv_linear,
  input  wire        det_tone_send,
  input  wire        det_tone_recv,
  input  wire        det_dt_send,
  input  wire        det_dt_recv,
  input  wire        det_supp_send,
  input  wire        det_supp_recv,
  input  wire        det_howl,
  input  wire        det_recv_idle,
  output reg         init_busy,
  output reg         howl_detect_off,
  output reg         auto_gain_off,
  output reg         tone_detect_off,
  output reg         path_bypass,
  output reg         mute_send,
  output reg         mute_recv,
  output reg         scale_active,
  output reg  [1:0]  estimate_subtract_off,
  output reg  [1:0]  learning_off,
  output reg  [1:0]  coef_clear,
  output reg  [1:0]  offset_null_off,
  output reg  [1:0]  comfort_noise_off,
  output reg  [1:0]  suppressor_off,
  output reg  [1:0]  speed_ctrl_off,
  output reg         weighting_off
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg  [7:0] main_ctrl_r;
  reg  [7:0] line_canceller_ctrl_r;
  reg  [7:0] acoustic_canceller_ctrl_r;
  reg  [3:0] init_cnt_r;
  reg  [3:0] init_cnt_nxt;
  reg  [7:0] line_status_nxt;
  reg  [7:0] acoustic_status_nxt;
  reg  [7:0] rdata_nxt;
  reg  [2:0] lin_s_r;
  reg  [2:0] lin_r_r;
  reg        lin_s_q;
  reg        lin_r_q;

  wire       init_start = reg_wr && (reg_addr == `ECR_ADDR_MAIN_CTRL) &&
                          reg_wdata[`ECR_MC_SOFT_RESET];
  wire       init_run   = (init_cnt_r != 4'h0);

  // ****************************************************************
  // Format straps from the serial ports, three-stage sampled
  // ****************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      lin_s_r <= 3'h0;
      lin_r_r <= 3'h0;
      lin_s_q <= 1'b0;
      lin_r_q <= 1'b0;
    end else begin
      lin_s_r <= {lin_s_r[1:0], send_linear};
      lin_r_r <= {lin_r_r[1:0], recv_linear};
      if (lin_s_r[2] == lin_s_r[1]) begin
        lin_s_q <= lin_s_r[2];
      end
      if (lin_r_r[2] == lin_r_r[1]) begin
        lin_r_q <= lin_r_r[2];
      end
    end
  end

  // ****************************************************************
  // Soft reset sequencing
  // ****************************************************************
  always @* begin
    init_cnt_nxt = init_cnt_r;
    if (init_start) begin
      init_cnt_nxt = INIT_CYCLES[3:0];
    end else if (init_run) begin
      init_cnt_nxt = init_cnt_r - 4'h1;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Writes during initialization are dropped, except a soft reset write, which restarts the sequence.
  always @(posedge clock) begin
    if (sys_rst) begin
      main_ctrl_r               <= `ECR_RST_MAIN_CTRL;
      line_canceller_ctrl_r     <= `ECR_RST_LINE_CTRL;
      acoustic_canceller_ctrl_r <= `ECR_RST_ACOU_CTRL;
      init_cnt_r                <= 4'h0;
    end else begin
      init_cnt_r <= init_cnt_nxt;
      if (init_start) begin
        main_ctrl_r               <= `ECR_RST_MAIN_CTRL | 8'h01;
        line_canceller_ctrl_r     <= `ECR_RST_LINE_CTRL;
        acoustic_canceller_ctrl_r <= `ECR_RST_ACOU_CTRL;
      end else if (init_run) begin
        if (init_cnt_r == 4'h1) begin
          main_ctrl_r[`ECR_MC_SOFT_RESET] <= 1'b0;
        end
      end else if (reg_wr) begin
        case (reg_addr)
          `ECR_ADDR_MAIN_CTRL: begin
            main_ctrl_r <= reg_wdata;
          end
          `ECR_ADDR_LINE_CTRL: begin
            line_canceller_ctrl_r <= reg_wdata;
          end
          `ECR_ADDR_ACOU_CTRL: begin
            acoustic_canceller_ctrl_r <= reg_wdata;
          end
          default: begin
            // Status and unmapped writes are ignored
            main_ctrl_r <= main_ctrl_r;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Status composition and read mux
  // ****************************************************************
  always @* begin
    line_status_nxt     = 8'h00;
    acoustic_status_nxt = 8'h00;
    line_status_nxt[`ECR_ST_TONE_PATH]      = det_tone_recv & ~tone_detect_off;
    line_status_nxt[`ECR_ST_TONE_ANY]       = (det_tone_recv | det_tone_send) & ~tone_detect_off;
    line_status_nxt[`ECR_ST_DOUBLE_TALK]    = det_dt_recv;
    line_status_nxt[`ECR_ST_SUPP_ACTIVE]    = det_supp_recv;
    acoustic_status_nxt[`ECR_ST_TONE_PATH]  = det_tone_send & ~tone_detect_off;
    acoustic_status_nxt[`ECR_ST_TONE_ANY]   = (det_tone_send | det_tone_recv) & ~tone_detect_off;
    acoustic_status_nxt[`ECR_ST_DOUBLE_TALK] = det_dt_send;
    acoustic_status_nxt[`ECR_ST_SUPP_ACTIVE] = det_supp_send;
    acoustic_status_nxt[`ECR_ST_HOWL]       = det_howl & ~howl_detect_off;
    acoustic_status_nxt[`ECR_ST_RECV_IDLE]  = det_recv_idle;
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `ECR_ADDR_MAIN_CTRL: begin
          rdata_nxt = main_ctrl_r;
        end
        `ECR_ADDR_LINE_CTRL: begin
          rdata_nxt = line_canceller_ctrl_r;
        end
        `ECR_ADDR_LINE_STATUS: begin
          rdata_nxt = line_status_nxt;
        end
        `ECR_ADDR_ACOU_CTRL: begin
          rdata_nxt = acoustic_canceller_ctrl_r;
        end
        `ECR_ADDR_ACOU_STATUS: begin
          rdata_nxt = acoustic_status_nxt;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registered read data and outputs to the processing core
  // ****************************************************************
  // One cycle of lag behind the register; the sample rate is far slower.
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata             <= 8'h00;
      init_busy             <= 1'b0;
      howl_detect_off       <= 1'b0;
      auto_gain_off         <= 1'b0;
      tone_detect_off       <= 1'b0;
      path_bypass           <= 1'b0;
      mute_send             <= 1'b0;
      mute_recv             <= 1'b0;
      scale_active          <= 1'b0;
      estimate_subtract_off <= 2'h0;
      learning_off          <= 2'h0;
      coef_clear            <= 2'h0;
      offset_null_off       <= 2'h0;
      comfort_noise_off     <= 2'h0;
      suppressor_off        <= 2'h0;
      speed_ctrl_off        <= 2'h0;
      weighting_off         <= 1'b0;
    end else begin
      reg_rdata       <= rdata_nxt;
      init_busy       <= init_run | init_start;
      howl_detect_off <= main_ctrl_r[`ECR_MC_HOWL_OFF];
      auto_gain_off   <= main_ctrl_r[`ECR_MC_AGC_OFF];
      tone_detect_off <= main_ctrl_r[`ECR_MC_TONE_OFF];
      path_bypass     <= main_ctrl_r[`ECR_MC_BYPASS];
      mute_send       <= main_ctrl_r[`ECR_MC_MUTE_SEND];
      mute_recv       <= main_ctrl_r[`ECR_MC_MUTE_RECV];
      scale_active    <= line_canceller_ctrl_r[`ECR_CC_TOP] & main_ctrl_r[`ECR_MC_LIMIT] &
                         lin_s_q & lin_r_q;
      // Bit 0 is the line canceller, bit 1 the acoustic canceller
      estimate_subtract_off <= {acoustic_canceller_ctrl_r[`ECR_CC_EST_OFF],
                                line_canceller_ctrl_r[`ECR_CC_EST_OFF]};
      learning_off          <= {acoustic_canceller_ctrl_r[`ECR_CC_LEARN_OFF],
                                line_canceller_ctrl_r[`ECR_CC_LEARN_OFF]};
      coef_clear            <= {acoustic_canceller_ctrl_r[`ECR_CC_COEF_CLEAR],
                                line_canceller_ctrl_r[`ECR_CC_COEF_CLEAR]};
      offset_null_off       <= {acoustic_canceller_ctrl_r[`ECR_CC_OFFSET_OFF],
                                line_canceller_ctrl_r[`ECR_CC_OFFSET_OFF]};
      comfort_noise_off     <= {acoustic_canceller_ctrl_r[`ECR_CC_NOISE_OFF],
                                line_canceller_ctrl_r[`ECR_CC_NOISE_OFF]};
      suppressor_off        <= {acoustic_canceller_ctrl_r[`ECR_CC_SUPP_OFF],
                                line_canceller_ctrl_r[`ECR_CC_SUPP_OFF]};
      speed_ctrl_off        <= {acoustic_canceller_ctrl_r[`ECR_CC_SPEED_OFF],
                                line_canceller_ctrl_r[`ECR_CC_SPEED_OFF]};
      weighting_off         <= acoustic_canceller_ctrl_r[`ECR_CC_TOP];
    end
  end

endmodule
`default_nettype wire

/* File: verification/ecr_regs_checker.sv */
// Assertion checker for the echo canceller register bank
`timescale 1ns/100ps
`default_nettype none
module ecr_regs_checker #(
  parameter INIT_CYCLES = 8
) (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       send_linear,
  input wire logic       det_tone_send,
  input wire logic       det_tone_recv,
  input wire logic       det_dt_send,
  input wire logic       det_dt_recv,
  input wire logic       det_supp_send,
  input wire logic       det_supp_recv,
  input wire logic       det_howl,
  input wire logic       det_recv_idle,
  input wire logic       init_busy,
  input wire logic       howl_detect_off,
  input wire logic       tone_detect_off,
  input wire logic       mute_send,
  input wire logic       scale_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire rd_acou = reg_rd && reg_addr == 8'h22;
  wire rd_line = reg_rd && reg_addr == 8'h02;
  int  busy_cnt_r;
  // ****************************************************************
  // Init length counter, too long for a repetition
  // ****************************************************************
  always @(posedge clock) busy_cnt_r <= (sys_rst || !init_busy) ? 0 : busy_cnt_r + 1;

  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_ACOU_STATUS: assert property (rd_acou && !tone_detect_off && !howl_detect_off |=>
    reg_rdata == {1'b0, $past(det_recv_idle), $past(det_howl), 1'b0, $past(det_supp_send), $past(det_dt_send),
    $past(det_tone_send || det_tone_recv), $past(det_tone_send)}) else $error("acoustic status wrong");
  AST_LINE_STATUS: assert property (rd_line && !tone_detect_off |=> reg_rdata == {4'h0,
    $past(det_supp_recv), $past(det_dt_recv), $past(det_tone_send || det_tone_recv), $past(det_tone_recv)})
    else $error("line status wrong");
  AST_TONE_GATED: assert property (rd_acou && tone_detect_off |=> reg_rdata[1:0] == 2'b00)
    else $error("tone flag while detector off");
  AST_HOWL_GATED: assert property (rd_acou && howl_detect_off |=> !reg_rdata[5])
    else $error("howl flag while detector off");
  AST_SCALE_LINEAR: assert property ((!send_linear)[*6] |-> !scale_active)
    else $error("scaling without linear port");
  AST_INIT_START: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[0] && !init_busy |-> ##[1:2] init_busy)
    else $error("soft init did not start");
  AST_INIT_LEN: assert property (busy_cnt_r <= INIT_CYCLES + 2)
    else $error("soft init too long");
  AST_INIT_CLEARS: assert property ($fell(init_busy) |-> !mute_send && !tone_detect_off && !howl_detect_off)
    else $error("controls not cleared by soft init");
  AST_CTRL_HOLD: assert property ((!reg_wr && !init_busy)[*3] |=> $stable(mute_send) && $stable(tone_detect_off))
    else $error("control changed without a write");
endmodule

bind ecr_regs ecr_regs_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .send_linear(send_linear), .det_tone_send(det_tone_send),
  .det_tone_recv(det_tone_recv), .det_dt_send(det_dt_send), .det_dt_recv(det_dt_recv),
  .det_supp_send(det_supp_send), .det_supp_recv(det_supp_recv), .det_howl(det_howl),
  .det_recv_idle(det_recv_idle), .init_busy(init_busy), .howl_detect_off(howl_detect_off),
  .tone_detect_off(tone_detect_off), .mute_send(mute_send), .scale_active(scale_active));
`default_nettype wire

/* File: verification/ecr_host.sv */
// Host controller model for the register port
`timescale 1ns/100ps
`default_nettype none
module ecr_host (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr = 8'h00,
  output var  logic [7:0] reg_wdata = 8'h00,
  output var  logic       reg_wr = 1'b0,
  output var  logic       reg_rd = 1'b0
);
  // Never aimed at the status registers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: verification/test_echo_canceller_control_regs.sv */
// Self-checking testbench for the echo canceller register bank
`timescale 1ns/100ps
`default_nettype none
module test_echo_canceller_control_regs;
  logic       clock;
  logic       sys_rst = 1'b1;
  logic       send_linear = 1'b0;
  logic       recv_linear = 1'b0;
  logic [7:0] det = 8'h00;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, init_busy, howl_detect_off, auto_gain_off, tone_detect_off, path_bypass;
  wire        mute_send, mute_recv, scale_active, weighting_off;
  wire  [1:0] est_off, learn_off, coef_clr, offs_off, noise_off, supp_off, speed_off;
  wire  [7:0] main_out = {1'b0, mute_recv, mute_send, path_bypass, tone_detect_off, auto_gain_off, howl_detect_off, 1'b0};
  wire  [7:0] line_out = {1'b0, speed_off[0], supp_off[0], noise_off[0], offs_off[0], coef_clr[0], learn_off[0], est_off[0]};
  wire  [7:0] acou_out = {weighting_off, speed_off[1], supp_off[1], noise_off[1], offs_off[1], coef_clr[1], learn_off[1],
                          est_off[1]};
  int         mismatches = 0;
  int         samples_checked = 0;
  logic [7:0] v;

  ecr_host host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  ecr_regs #(.INIT_CYCLES(6)) uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .send_linear(send_linear), .recv_linear(recv_linear),
    .det_tone_send(det[0]), .det_tone_recv(det[1]), .det_dt_send(det[2]), .det_dt_recv(det[3]),
    .det_supp_send(det[4]), .det_supp_recv(det[5]), .det_howl(det[6]), .det_recv_idle(det[7]),
    .init_busy(init_busy), .howl_detect_off(howl_detect_off), .auto_gain_off(auto_gain_off),
    .tone_detect_off(tone_detect_off), .path_bypass(path_bypass), .mute_send(mute_send), .mute_recv(mute_recv),
    .scale_active(scale_active), .estimate_subtract_off(est_off), .learning_off(learn_off), .coef_clear(coef_clr),
    .offset_null_off(offs_off), .comfort_noise_off(noise_off), .suppressor_off(supp_off),
    .speed_ctrl_off(speed_off), .weighting_off(weighting_off));

  // ****************************************************************
  // Compare helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, v);
    chk(v, exp);
  endtask
  function automatic logic [7:0] acou_exp(input logic [7:0] d, input logic toff, input logic hoff);
    return {1'b0, d[7], d[6] & !hoff, 1'b0, d[4], d[2], (d[0] | d[1]) & !toff, d[0] & !toff};
  endfunction
  function automatic logic [7:0] line_exp(input logic [7:0] d, input logic toff);
    return {4'h0, d[5], d[3], (d[0] | d[1]) & !toff, d[1] & !toff};
  endfunction

  task automatic t_regs;
    logic [7:0] p;
    for (int i = 0; i < 2; i++) begin
      p = i ? 8'hd4 : 8'h2a;
      host.wr(8'h00, p);
      host.wr(8'h01, ~p);
      host.wr(8'h21, p);
      host.wr(8'h10, 8'hff);
      repeat (2) @(posedge clock);
      chk(main_out, {1'b0, p[6:1], 1'b0});
      chk(line_out, {1'b0, ~p[6:0]});
      chk(acou_out, p);
      rdchk(8'h00, p);
      rdchk(8'h01, ~p);
      rdchk(8'h21, p);
      rdchk(8'h10, 8'h00);
    end
    $display("test registers done");
  endtask

  task automatic t_status;
    logic [7:0] d;
    host.wr(8'h00, 8'h00);
    for (int i = 0; i < 9; i++) begin
      d = (i < 8) ? (8'h01 << i) : 8'hff;
      det <= d;
      rdchk(8'h22, acou_exp(d, 1'b0, 1'b0));
      rdchk(8'h02, line_exp(d, 1'b0));
    end
    host.wr(8'h00, 8'h0a);
    repeat (2) @(posedge clock);
    rdchk(8'h22, acou_exp(8'hff, 1'b1, 1'b1));
    rdchk(8'h02, line_exp(8'hff, 1'b1));
    det <= 8'h00;
    $display("test status done");
  endtask

  task automatic t_scale;
    host.wr(8'h00, 8'h80);
    host.wr(8'h01, 8'h80);
    send_linear <= 1'b1;
    recv_linear <= 1'b1;
    repeat (8) @(posedge clock);
    chk({7'h00, scale_active}, 8'h01);
    recv_linear <= 1'b0;
    repeat (8) @(posedge clock);
    chk({7'h00, scale_active}, 8'h00);
    recv_linear <= 1'b1;
    host.wr(8'h00, 8'h00);
    repeat (8) @(posedge clock);
    chk({7'h00, scale_active}, 8'h00);
    // Both scaling bits set again, but the send port is no longer linear
    host.wr(8'h00, 8'h80);
    send_linear <= 1'b0;
    repeat (8) @(posedge clock);
    chk({7'h00, scale_active}, 8'h00);
    $display("test scaling done");
  endtask

  task automatic t_soft;
    // Controls set first so the soft init has something to clear
    host.wr(8'h00, 8'h6a);
    host.wr(8'h01, 8'h15);
    host.wr(8'h00, 8'h41);
    host.wr(8'h21, 8'h33);
    chk({7'h00, init_busy}, 8'h01);
    rdchk(8'h00, 8'h01);
    for (int n = 0; n < 40 && init_busy !== 1'b0; n++) @(posedge clock);
    chk({7'h00, init_busy}, 8'h00);
    chk(main_out, 8'h00);
    rdchk(8'h00, 8'h00);
    rdchk(8'h01, 8'h00);
    rdchk(8'h21, 8'h00);
    $display("test soft reset done");
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    rdchk(8'h00, 8'h00);
    rdchk(8'h22, 8'h00);
    t_regs;
    t_status;
    t_scale;
    t_soft;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
